// [hdl/plt_pkg.sv]
/*
  Shared constants and types of the position latch and trippoint block.
  Assumes a 32-bit AHB-Lite register bus and one 25 MHz controller clock.
*/
package plt_pkg;

  // Byte offsets of the registers
  localparam logic [7:0] ADDR_ARM = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CAPTURED = 8'h0C;
  localparam logic [7:0] ADDR_WAIT_IN = 8'h10;
  localparam logic [7:0] ADDR_WAIT_MV = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_CLR = 8'h1C;
  localparam logic [7:0] ADDR_INT_EN = 8'h20;
  localparam logic [7:0] ADDR_MAIN_COUNT = 8'h24;
  localparam logic [7:0] ADDR_AUX_COUNT = 8'h28;

  // Arm command fields
  localparam int ARM_BIT = 0;
  localparam int ARM_AUX_BIT = 1;
  localparam int ARM_INDEX_BIT = 2;
  // Configuration fields
  localparam int CFG_INVERT_BIT = 0;
  // Input wait fields
  localparam int WIN_NUM_LSB = 0;
  localparam int WIN_NUM_W = 7;
  localparam int WIN_LOW_BIT = 7;
  // Move wait fields
  localparam int WMV_AXIS_BIT = 0;
  localparam int WMV_VECTOR_BIT = 1;
  // Interrupt event bits
  localparam int EVT_W = 3;
  localparam int EVT_CAPTURE = 0;
  localparam int EVT_INPUT = 1;
  localparam int EVT_MOVE = 2;

  // Condition source numbers
  localparam logic [6:0] SRC_GEN_FIRST = 7'h01;
  localparam logic [6:0] SRC_GEN_LAST = 7'h08;
  localparam logic [6:0] SRC_AUX_A = 7'h51;
  localparam logic [6:0] SRC_AUX_B = 7'h52;

  // Synchronised input vector layout
  localparam int GEN_W = 8;
  localparam int SYNC_W = 13;
  localparam int IDX_ENC_BASE = 8;
  localparam int IDX_INDEX = 12;
  localparam int LATCH_INPUT = 0;

  localparam int CNT_W = 32;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef struct packed {
    logic a;
    logic b;
  } plt_enc_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } plt_dphase_t;

endpackage

// [hdl/plt_latch_trip.sv]
/*
  Position latch with arm, capture and readback, two quadrature counters,
  input-level and move-complete trippoints, AHB-Lite register slave and
  one level interrupt. Assumes a single AHB-Lite master, the profiler flags
  on the same clock, and encoder and input pins asynchronous to hclk.
*/
`timescale 1ns/1ns
`default_nettype none

module plt_latch_trip (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] gen_in,
  input wire plt_pkg::plt_enc_t enc_main,
  input wire plt_pkg::plt_enc_t enc_aux,
  input wire logic enc_index,
  input wire logic prof_axis_active,
  input wire logic prof_vector_active,
  output logic irq,
  output logic exec_stall
);

  logic [plt_pkg::SYNC_W-1:0] raw;
  logic [plt_pkg::SYNC_W-1:0] s1_ff;
  logic [plt_pkg::SYNC_W-1:0] s2_ff;
  logic [plt_pkg::SYNC_W-1:0] s3_ff;
  logic [plt_pkg::SYNC_W-1:0] filt_ff;
  logic [plt_pkg::SYNC_W-1:0] prev_ff;
  logic [plt_pkg::CNT_W-1:0] count_ff [2];
  plt_pkg::plt_dphase_t dp_ff;
  logic take;
  logic wr_en;
  logic armed_ff;
  logic src_aux_ff;
  logic index_mode_ff;
  logic invert_ff;
  logic [plt_pkg::CNT_W-1:0] capt_ff;
  logic arm_wr;
  logic trig_dig;
  logic trig;
  logic cap_evt;
  logic [plt_pkg::CNT_W-1:0] sel_count;
  logic in_wait_ff;
  logic [6:0] in_num_ff;
  logic in_low_ff;
  logic in_level;
  logic in_met;
  logic in_num_ok;
  logic [6:0] wr_num;
  logic mv_wait_ff;
  logic [1:0] mv_mask_ff;
  logic mv_done;
  logic [plt_pkg::EVT_W-1:0] evt;
  logic [plt_pkg::EVT_W-1:0] int_stat_ff;
  logic [plt_pkg::EVT_W-1:0] int_en_ff;
  logic [plt_pkg::EVT_W-1:0] nxt_int_stat;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_ff;
  logic irq_ff;
  logic stall_ff;

  assign raw = {enc_index, enc_aux.b, enc_aux.a, enc_main.b, enc_main.a, gen_in};

  // Three-stage synchroniser, value accepted when stages two and three agree
  for (genvar i = 0; i < plt_pkg::SYNC_W; i++) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_ff[i] <= 1'b1;
        s2_ff[i] <= 1'b1;
        s3_ff[i] <= 1'b1;
        filt_ff[i] <= 1'b1;
        prev_ff[i] <= 1'b1;
      end else begin
        s1_ff[i] <= raw[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          filt_ff[i] <= s3_ff[i];
        end
        prev_ff[i] <= filt_ff[i];
      end
    end
  end

  // Quadrature x4 counters: 0 main, 1 aux; counts up when A leads B
  for (genvar e = 0; e < 2; e++) begin : g_quad
    localparam int IA = plt_pkg::IDX_ENC_BASE + 2 * e;
    localparam int IB = IA + 1;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        count_ff[e] <= plt_pkg::RESET_WORD;
      end else if ((filt_ff[IA] ^ prev_ff[IA]) ^ (filt_ff[IB] ^ prev_ff[IB])) begin
        if (prev_ff[IA] ^ filt_ff[IB]) begin
          count_ff[e] <= count_ff[e] - 32'h0000_0001;
        end else begin
          count_ff[e] <= count_ff[e] + 32'h0000_0001;
        end
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign take = hsel && hready && htrans[1];
  assign wr_en = dp_ff.valid && dp_ff.write;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_ff <= '0;
    end else if (hready) begin
      dp_ff.valid <= take;
      dp_ff.write <= hwrite;
      dp_ff.addr <= haddr[7:0];
    end
  end

  always_comb begin
    rd_mux = plt_pkg::RESET_WORD;
    unique case (haddr[7:0])
      plt_pkg::ADDR_CFG: rd_mux[plt_pkg::CFG_INVERT_BIT] = invert_ff;
      plt_pkg::ADDR_STATUS: rd_mux[6:0] = {index_mode_ff, src_aux_ff, mv_wait_ff, in_wait_ff,
        prof_vector_active, prof_axis_active, armed_ff};
      plt_pkg::ADDR_CAPTURED: rd_mux = capt_ff;
      plt_pkg::ADDR_WAIT_IN: rd_mux[7:0] = {in_low_ff, in_num_ff};
      plt_pkg::ADDR_WAIT_MV: rd_mux[1:0] = mv_mask_ff;
      plt_pkg::ADDR_INT_STAT: rd_mux[plt_pkg::EVT_W-1:0] = int_stat_ff;
      plt_pkg::ADDR_INT_EN: rd_mux[plt_pkg::EVT_W-1:0] = int_en_ff;
      plt_pkg::ADDR_MAIN_COUNT: rd_mux = count_ff[0];
      plt_pkg::ADDR_AUX_COUNT: rd_mux = count_ff[1];
      default: rd_mux = plt_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= plt_pkg::RESET_WORD;
    end else if (take && !hwrite) begin
      hrdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      invert_ff <= 1'b0;
      int_en_ff <= '0;
    end else if (wr_en) begin
      if (dp_ff.addr == plt_pkg::ADDR_CFG) begin
        invert_ff <= hwdata[plt_pkg::CFG_INVERT_BIT];
      end
      if (dp_ff.addr == plt_pkg::ADDR_INT_EN) begin
        int_en_ff <= hwdata[plt_pkg::EVT_W-1:0];
      end
    end
  end

  // Latch arm and capture
  assign arm_wr = wr_en && (dp_ff.addr == plt_pkg::ADDR_ARM) && hwdata[plt_pkg::ARM_BIT];
  assign trig_dig = invert_ff ?
    (filt_ff[plt_pkg::LATCH_INPUT] && !prev_ff[plt_pkg::LATCH_INPUT]) :
    (!filt_ff[plt_pkg::LATCH_INPUT] && prev_ff[plt_pkg::LATCH_INPUT]);
  assign trig = index_mode_ff ?
    (filt_ff[plt_pkg::IDX_INDEX] && !prev_ff[plt_pkg::IDX_INDEX]) : trig_dig;
  assign cap_evt = armed_ff && trig && !arm_wr;
  assign sel_count = src_aux_ff ? count_ff[1] : count_ff[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_ff <= 1'b0;
      src_aux_ff <= 1'b0;
      index_mode_ff <= 1'b0;
    end else if (arm_wr) begin
      armed_ff <= 1'b1;
      index_mode_ff <= hwdata[plt_pkg::ARM_INDEX_BIT];
      src_aux_ff <= hwdata[plt_pkg::ARM_AUX_BIT] && !hwdata[plt_pkg::ARM_INDEX_BIT];
    end else if (cap_evt) begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_ff <= plt_pkg::RESET_WORD;
    end else if (cap_evt) begin
      capt_ff <= sel_count;
    end
  end

  // Input trippoint, local pins only
  assign wr_num = hwdata[plt_pkg::WIN_NUM_LSB +: plt_pkg::WIN_NUM_W];
  assign in_num_ok = ((wr_num >= plt_pkg::SRC_GEN_FIRST) && (wr_num <= plt_pkg::SRC_GEN_LAST))
    || (wr_num == plt_pkg::SRC_AUX_A) || (wr_num == plt_pkg::SRC_AUX_B);

  always_comb begin
    in_level = 1'b0;
    if (in_num_ff == plt_pkg::SRC_AUX_A) begin
      in_level = filt_ff[plt_pkg::IDX_ENC_BASE + 2];
    end else if (in_num_ff == plt_pkg::SRC_AUX_B) begin
      in_level = filt_ff[plt_pkg::IDX_ENC_BASE + 3];
    end else begin
      in_level = filt_ff[3'(in_num_ff - 7'h01)];
    end
  end

  assign in_met = in_wait_ff && (in_level == !in_low_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_wait_ff <= 1'b0;
      in_num_ff <= plt_pkg::SRC_GEN_FIRST;
      in_low_ff <= 1'b0;
    end else if (wr_en && (dp_ff.addr == plt_pkg::ADDR_WAIT_IN) && in_num_ok) begin
      in_wait_ff <= 1'b1;
      in_num_ff <= wr_num;
      in_low_ff <= hwdata[plt_pkg::WIN_LOW_BIT];
    end else if (in_met) begin
      in_wait_ff <= 1'b0;
    end
  end

  // Move-complete trippoint, from profiler flags only
  assign mv_done = !((mv_mask_ff[plt_pkg::WMV_AXIS_BIT] && prof_axis_active) ||
    (mv_mask_ff[plt_pkg::WMV_VECTOR_BIT] && prof_vector_active));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mv_wait_ff <= 1'b0;
      mv_mask_ff <= 2'h0;
    end else if (wr_en && (dp_ff.addr == plt_pkg::ADDR_WAIT_MV) && (hwdata[1:0] != 2'h0)) begin
      mv_wait_ff <= 1'b1;
      mv_mask_ff <= hwdata[1:0];
    end else if (mv_wait_ff && mv_done) begin
      mv_wait_ff <= 1'b0;
    end
  end

  // Interrupts: set wins over clear
  always_comb begin
    evt = '0;
    evt[plt_pkg::EVT_CAPTURE] = cap_evt;
    evt[plt_pkg::EVT_INPUT] = in_met;
    evt[plt_pkg::EVT_MOVE] = mv_wait_ff && mv_done;
    nxt_int_stat = int_stat_ff;
    if (wr_en && (dp_ff.addr == plt_pkg::ADDR_INT_CLR)) begin
      nxt_int_stat = int_stat_ff & ~hwdata[plt_pkg::EVT_W-1:0];
    end
    nxt_int_stat = nxt_int_stat | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= '0;
      irq_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      int_stat_ff <= nxt_int_stat;
      irq_ff <= |(int_stat_ff & int_en_ff);
      stall_ff <= in_wait_ff || mv_wait_ff;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign irq = irq_ff;
  assign exec_stall = stall_ff;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_arm_write;
    arm_wr;
  endsequence

  sequence s_fire;
    armed_ff && trig && !arm_wr;
  endsequence

  sequence s_in_write;
    wr_en && (dp_ff.addr == plt_pkg::ADDR_WAIT_IN);
  endsequence

  sequence s_mv_write;
    wr_en && (dp_ff.addr == plt_pkg::ADDR_WAIT_MV);
  endsequence

  AST_ARM_SETS: assert property (s_arm_write |=> armed_ff)
    else $error("arm write did not arm the latch");
  AST_FALL_CAPTURE: assert property (
    s_fire ##0 (!invert_ff && !index_mode_ff && !src_aux_ff)
    |=> (capt_ff == $past(count_ff[0])) && !armed_ff)
    else $error("falling trigger did not capture main count");
  AST_AUX_CAPTURE: assert property (s_fire ##0 src_aux_ff |=> capt_ff == $past(count_ff[1]))
    else $error("aux capture took wrong count");
  AST_INDEX_CAPTURE: assert property (
    s_fire ##0 index_mode_ff |=> capt_ff == $past(count_ff[0]))
    else $error("index capture took wrong count");
  AST_ONE_SHOT: assert property (s_fire |=> !armed_ff ##1 (!armed_ff || $past(arm_wr)))
    else $error("armed flag not cleared by capture");
  AST_HOLD_UNARMED: assert property (!armed_ff |=> $stable(capt_ff))
    else $error("capture while not armed");
  AST_SYNC_AGREE: assert property (
    $changed(filt_ff[plt_pkg::LATCH_INPUT]) |-> $past(s2_ff[0]) == $past(s3_ff[0]))
    else $error("trigger accepted before sync stages agreed");
  AST_INVERT: assert property (
    armed_ff && invert_ff && !index_mode_ff && !arm_wr
    && $fell(filt_ff[plt_pkg::LATCH_INPUT]) |=> armed_ff)
    else $error("inverted trigger captured on falling edge");
  AST_IN_WAIT: assert property (
    in_met && !(wr_en && dp_ff.addr == plt_pkg::ADDR_WAIT_IN)
    |=> !in_wait_ff && int_stat_ff[plt_pkg::EVT_INPUT] ##1 (!stall_ff || $past(mv_wait_ff)))
    else $error("input wait not released on level");
  AST_IN_HOLD: assert property (in_wait_ff && !in_met |=> in_wait_ff)
    else $error("input wait released before level reached");
  AST_IN_REFUSED: assert property (s_in_write ##0 !in_num_ok |=> $stable(in_num_ff))
    else $error("input wait accepted an illegal source");
  AST_MV_HOLD: assert property (mv_wait_ff && !mv_done |=> mv_wait_ff)
    else $error("move wait released while profile active");
  AST_MV_REFUSED: assert property (
    s_mv_write ##0 (hwdata[1:0] == 2'h0) ##0 !mv_wait_ff |=> !mv_wait_ff)
    else $error("move wait armed by an empty mask");
  AST_AXIS_DONE: assert property (
    mv_wait_ff && mv_mask_ff == 2'h1 && !prof_axis_active
    && !(wr_en && dp_ff.addr == plt_pkg::ADDR_WAIT_MV) |=> !mv_wait_ff)
    else $error("axis wait not released by idle profiler");
  AST_VECTOR_DONE: assert property (
    mv_wait_ff && mv_mask_ff == 2'h2 && !prof_vector_active
    && !(wr_en && dp_ff.addr == plt_pkg::ADDR_WAIT_MV) |=> !mv_wait_ff)
    else $error("vector wait not released by idle vector profile");
  AST_STALL: assert property ((in_wait_ff || mv_wait_ff) |=> stall_ff)
    else $error("stall not raised during trippoint");
  AST_STALL_LOW: assert property (!in_wait_ff && !mv_wait_ff |=> !stall_ff)
    else $error("stall held with no trippoint pending");
  AST_STATUS_READ: assert property (
    take && !hwrite && haddr[7:0] == plt_pkg::ADDR_STATUS
    |=> hrdata_ff[0] == $past(armed_ff) && hrdata_ff[1] == $past(prof_axis_active))
    else $error("status read mismatch");
  AST_CAP_FLAG: assert property (s_fire |=> int_stat_ff[plt_pkg::EVT_CAPTURE])
    else $error("capture did not set its status bit");
  AST_IRQ: assert property (|(int_stat_ff & int_en_ff) |=> irq_ff)
    else $error("interrupt not raised");
  AST_IRQ_LOW: assert property (!(|(int_stat_ff & int_en_ff)) |=> !irq_ff)
    else $error("interrupt raised with no enabled status");

endmodule // plt_latch_trip

`default_nettype wire

// [verif/plt_partner.sv]
/*
  Far-side model: eight general inputs, main and aux quadrature encoders
  and the index pulse. Assumes callers enter its tasks just after a rising
  edge of hclk; general pins idle high, index idles low, encoders start
  at phase 11.
*/
`timescale 1ns/1ns
`default_nettype none

module plt_partner (
  input wire logic hclk,
  output var logic [7:0] gen_in,
  output var plt_pkg::plt_enc_t enc_main,
  output var plt_pkg::plt_enc_t enc_aux,
  output var logic enc_index
);
  logic [1:0] ph_main;
  logic [1:0] ph_aux;

  // Gray sequence 00,10,11,01 with A leading for up counts
  function automatic plt_pkg::plt_enc_t gray(input logic [1:0] p);
    case (p)
      2'h0: return plt_pkg::plt_enc_t'(2'h0);
      2'h1: return plt_pkg::plt_enc_t'(2'h2);
      2'h2: return plt_pkg::plt_enc_t'(2'h3);
      default: return plt_pkg::plt_enc_t'(2'h1);
    endcase
  endfunction

  initial begin
    gen_in = 8'hFF;
    ph_main = 2'h2;
    ph_aux = 2'h2;
    enc_main = gray(2'h2);
    enc_aux = gray(2'h2);
    enc_index = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic set_in(input int idx, input logic v);
    gen_in[idx] <= v;
    hold(4);
  endtask

  // One pin changes per step, steps well apart
  task automatic step(input bit aux, input bit up);
    if (aux) begin
      ph_aux = up ? ph_aux + 2'h1 : ph_aux - 2'h1;
      enc_aux <= gray(ph_aux);
    end else begin
      ph_main = up ? ph_main + 2'h1 : ph_main - 2'h1;
      enc_main <= gray(ph_main);
    end
    hold(5);
  endtask

  task automatic pulse_index;
    enc_index <= 1'b1;
    hold(4);
    enc_index <= 1'b0;
    hold(4);
  endtask
endmodule // plt_partner

`default_nettype wire

// [verif/tb_top.sv]
/*
  Self-checking bench of the latch and trippoint block over AHB-Lite.
  Assumes the partner model on the pins and hready tied to hreadyout.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, exec_stall, enc_index;
  logic prof_axis_active, prof_vector_active;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] gen_in;
  plt_pkg::plt_enc_t enc_main, enc_aux;
  int failures, total_checks;

  always #20 hclk = ~hclk;

  plt_latch_trip plt_latch_trip_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .gen_in(gen_in), .enc_main(enc_main), .enc_aux(enc_aux), .enc_index(enc_index),
    .prof_axis_active(prof_axis_active), .prof_vector_active(prof_vector_active),
    .irq(irq), .exec_stall(exec_stall));

  plt_partner plt_partner_i (.hclk(hclk), .gen_in(gen_in), .enc_main(enc_main),
    .enc_aux(enc_aux), .enc_index(enc_index));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic edge_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      failures++;
      stop_test;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    edge_ready;
    htrans <= 2'b00;
    hwdata <= d;
    edge_ready;
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    check(q, exp);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h00000000);
      n++;
    end while ((q & m) !== exp && n < 30);
    check(q & m, exp);
    if ((q & m) !== exp) stop_test;
  endtask

  task automatic stall_is(input logic v, input int n);
    int k;
    k = 0;
    while (exec_stall !== v && k < n) begin
      @(posedge hclk);
      k++;
    end
    check({31'h00000000, exec_stall}, {31'h00000000, v});
    if (exec_stall !== v) stop_test;
  endtask

  task automatic in_wait(input logic [7:0] w, input int act);
    wr(plt_pkg::ADDR_WAIT_IN, {24'h000000, w});
    stall_is(1'b1, 3);
    case (act)
      0: plt_partner_i.set_in(7, 1'b1);
      1: plt_partner_i.step(1'b1, 1'b1);
      2: plt_partner_i.step(1'b1, 1'b0);
      default: plt_partner_i.set_in(2, 1'b0);
    endcase
    stall_is(1'b0, 30);
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    prof_axis_active = 1'b0;
    prof_vector_active = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    check({29'h00000000, hresp, irq, exec_stall}, 32'h00000000);
    rd_chk(plt_pkg::ADDR_STATUS, 32'h00000000);
    rd_chk(plt_pkg::ADDR_CAPTURED, 32'h00000000);
    wr(8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h00000000);
    repeat (3) plt_partner_i.step(1'b0, 1'b1);
    repeat (2) plt_partner_i.step(1'b1, 1'b0);
    rd_chk(plt_pkg::ADDR_MAIN_COUNT, 32'h00000003);
    rd_chk(plt_pkg::ADDR_AUX_COUNT, 32'hFFFFFFFE);
    // Main capture on input 1 falling, then no capture while unarmed
    wr(plt_pkg::ADDR_INT_EN, 32'h00000007);
    wr(plt_pkg::ADDR_ARM, 32'h00000001);
    rd_chk(plt_pkg::ADDR_STATUS, 32'h00000001);
    plt_partner_i.set_in(0, 1'b0);
    poll(plt_pkg::ADDR_STATUS, 32'h00000001, 32'h00000000);
    rd_chk(plt_pkg::ADDR_CAPTURED, 32'h00000003);
    rd_chk(plt_pkg::ADDR_INT_STAT, 32'h00000001);
    check({31'h00000000, irq}, 32'h00000001);
    wr(plt_pkg::ADDR_INT_CLR, 32'h00000007);
    stall_is(1'b0, 1);
    repeat (2) @(posedge hclk);
    check({31'h00000000, irq}, 32'h00000000);
    plt_partner_i.set_in(0, 1'b1);
    plt_partner_i.step(1'b0, 1'b1);
    plt_partner_i.set_in(0, 1'b0);
    rd_chk(plt_pkg::ADDR_CAPTURED, 32'h00000003);
    plt_partner_i.set_in(0, 1'b1);
    wr(plt_pkg::ADDR_ARM, 32'h00000003);
    rd_chk(plt_pkg::ADDR_STATUS, 32'h00000021);
    plt_partner_i.set_in(0, 1'b0);
    poll(plt_pkg::ADDR_STATUS, 32'h00000001, 32'h00000000);
    rd_chk(plt_pkg::ADDR_CAPTURED, 32'hFFFFFFFE);
    // Inverted polarity captures on the rising edge
    wr(plt_pkg::ADDR_CFG, 32'h00000001);
    rd_chk(plt_pkg::ADDR_CFG, 32'h00000001);
    wr(plt_pkg::ADDR_ARM, 32'h00000001);
    plt_partner_i.set_in(0, 1'b1);
    poll(plt_pkg::ADDR_STATUS, 32'h00000001, 32'h00000000);
    rd_chk(plt_pkg::ADDR_CAPTURED, 32'h00000004);
    wr(plt_pkg::ADDR_CFG, 32'h00000000);
    plt_partner_i.step(1'b0, 1'b1);
    wr(plt_pkg::ADDR_ARM, 32'h00000005);
    rd_chk(plt_pkg::ADDR_STATUS, 32'h00000041);
    plt_partner_i.pulse_index;
    poll(plt_pkg::ADDR_STATUS, 32'h00000001, 32'h00000000);
    rd_chk(plt_pkg::ADDR_CAPTURED, 32'h00000005);
    wr(plt_pkg::ADDR_INT_CLR, 32'h00000007);
    // Input trippoints over general and aux sources, both levels
    plt_partner_i.set_in(7, 1'b0);
    in_wait(8'h08, 0);
    rd_chk(plt_pkg::ADDR_INT_STAT, 32'h00000002);
    check({31'h00000000, irq}, 32'h00000001);
    in_wait(8'h51, 1);
    plt_partner_i.step(1'b1, 1'b1);
    in_wait(8'hD2, 2);
    in_wait(8'h83, 3);
    wr(plt_pkg::ADDR_WAIT_IN, 32'h00000009);
    repeat (3) @(posedge hclk);
    check({31'h00000000, exec_stall}, 32'h00000000);
    rd_chk(plt_pkg::ADDR_WAIT_IN, 32'h00000083);
    rd_chk(plt_pkg::ADDR_AUX_COUNT, 32'hFFFFFFFF);
    // Move trippoints on the profiler flags, interrupt masked
    wr(plt_pkg::ADDR_INT_CLR, 32'h00000007);
    wr(plt_pkg::ADDR_INT_EN, 32'h00000003);
    prof_axis_active <= 1'b1;
    wr(plt_pkg::ADDR_WAIT_MV, 32'h00000001);
    stall_is(1'b1, 3);
    poll(plt_pkg::ADDR_STATUS, 32'h0000001F, 32'h00000012);
    prof_axis_active <= 1'b0;
    stall_is(1'b0, 30);
    poll(plt_pkg::ADDR_STATUS, 32'h00000012, 32'h00000000);
    rd_chk(plt_pkg::ADDR_INT_STAT, 32'h00000004);
    check({31'h00000000, irq}, 32'h00000000);
    prof_axis_active <= 1'b1;
    prof_vector_active <= 1'b1;
    wr(plt_pkg::ADDR_WAIT_MV, 32'h00000002);
    stall_is(1'b1, 3);
    prof_vector_active <= 1'b0;
    stall_is(1'b0, 30);
    wr(plt_pkg::ADDR_WAIT_MV, 32'h00000000);
    repeat (3) @(posedge hclk);
    check({31'h00000000, exec_stall}, 32'h00000000);
    prof_axis_active <= 1'b0;
    wr(plt_pkg::ADDR_INT_CLR, 32'h00000007);
    rd_chk(plt_pkg::ADDR_INT_STAT, 32'h00000000);
    stop_test;
  end
endmodule // tb_top

`default_nettype wire
